/* File: core/rfts_defs.vh */
// constants shared by the transmitter enable sequencer files
// assumes a 250 MHz system clock that stands for the crystal reference
`ifndef RFTS_DEFS_VH
`define RFTS_DEFS_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define RFTS_CLK_PERIOD_NS      4

// ----------------------------------------------------------------------
// timing (times in ns, counts in cycles)
// ----------------------------------------------------------------------
// lock happens before the 1 ms limit; the exact figure is a free choice
`define RFTS_LOCK_TIME_NS       900000
`define RFTS_LOCK_CYCLES        (`RFTS_LOCK_TIME_NS / `RFTS_CLK_PERIOD_NS)
`define RFTS_SETTLE_TIME_NS     1000000
`define RFTS_SETTLE_CYCLES      ((`RFTS_SETTLE_TIME_NS + `RFTS_CLK_PERIOD_NS - 1) / `RFTS_CLK_PERIOD_NS)
// one symbol at 32 kbaud lasts 31250 ns
`define RFTS_SYMBOL_TIME_NS     31250
`define RFTS_SYMBOL_CYCLES      ((`RFTS_SYMBOL_TIME_NS + `RFTS_CLK_PERIOD_NS - 1) / `RFTS_CLK_PERIOD_NS)
`define RFTS_CNT_W              20

// ----------------------------------------------------------------------
// pll and clock output
// ----------------------------------------------------------------------
`define RFTS_PLL_RATIO          6'h20
`define RFTS_CLKOUT_DIV_W       2

// ----------------------------------------------------------------------
// modes
// ----------------------------------------------------------------------
`define RFTS_MODE_STANDBY       2'h0
`define RFTS_MODE_LOCKING       2'h1
`define RFTS_MODE_READY         2'h2
`define RFTS_MODE_TRANSMIT      2'h3

`endif

/* File: core/rfts_clk_div4.v */
// divide-by-four clock output driver for the controller
// assumes run_i is a level from the sequencer: block enable gated by the registered driver enable
module rfts_clk_div4
(
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       run_i,
    // divided clock
    output reg        clock_out_o
);

`include "rfts_defs.vh"

    reg [`RFTS_CLKOUT_DIV_W-1:0] phase;

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    // restarts from zero on every enable so the first period is whole
    always @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            phase       <= 2'h0;
            clock_out_o <= 1'b0;
        end
        else
        begin
            phase       <= phase + 2'h1;
            clock_out_o <= phase[1];
        end
    end

endmodule

/* File: core/rfts_sequencer.v */
// mode sequencer of the pll transmitter: enables, lock wait, keying
// assumes block_enable_i, amplifier_on_request_i and the keying switch
// are synchronous to clk_i, which stands for the crystal reference

`include "rfts_defs.vh"

// What this block does
// - both enables low: oscillator, pll, clock driver and amplifier all off
// - block enable high switches on oscillator, pll and clock output driver
// - enabled with amplifier request low: pll runs, amplifier off, clock delivered
// - both enables high: pll, oscillator, clock driver and amplifier all on
// - amplifier follows its request input while block enable is high; controller keys it with data
// - pll locks and clock output is stable within one millisecond of enable
// - pll locks its output to thirty-two times the crystal frequency
// - keying switch closed gives the lower frequency, open the higher
// - block enable low returns the transmitter to standby
// - clock output runs at a quarter of the crystal frequency
module rfts_sequencer
#(
    parameter LOCK_CYCLES   = `RFTS_LOCK_CYCLES,
    parameter SETTLE_CYCLES = `RFTS_SETTLE_CYCLES,
    parameter SYMBOL_CYCLES = `RFTS_SYMBOL_CYCLES
)
(
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // control pins from the controller
    input  wire        block_enable_i,
    input  wire        amplifier_on_request_i,
    input  wire        keying_switch_closed_i,
    // analog block enables
    output reg         crystal_oscillator_on_o,
    output reg         pll_on_o,
    output reg         clk_driver_on_o,
    output reg         amplifier_on_o,
    // clock output to the controller
    output wire        clock_out_o,
    // status
    output reg  [1:0]  mode_o,
    output reg         pll_locked_o,
    output reg         settled_o,
    output reg  [5:0]  pll_ratio_o,
    output reg         frequency_keying_high_o,
    output reg  [15:0] carrier_phase_o,
    // sequence checks on the controller side
    output reg         early_amplifier_o,
    output reg         amplifier_while_off_o,
    output reg         rate_violation_o
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam ST_STANDBY  = `RFTS_MODE_STANDBY;
    localparam ST_LOCKING  = `RFTS_MODE_LOCKING;
    localparam ST_READY    = `RFTS_MODE_READY;
    localparam ST_TRANSMIT = `RFTS_MODE_TRANSMIT;

    reg [1:0]              state;
    reg [1:0]              next_state;
    reg [`RFTS_CNT_W-1:0]  enable_cnt;
    reg [`RFTS_CNT_W-1:0]  symbol_cnt;
    reg                    amp_req_prev;
    reg                    switch_prev;
    reg                    symbol_seen;
    wire                   locked_now;
    wire                   settled_now;
    wire                   mod_edge;
    wire                   clk_run;

    assign locked_now  = (enable_cnt >= LOCK_CYCLES);
    assign settled_now = (enable_cnt >= SETTLE_CYCLES);

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    always @*
    begin
        next_state = state;
        case (state)
            ST_STANDBY:
            begin
                if (block_enable_i)
                    next_state = ST_LOCKING;
            end
            ST_LOCKING:
            begin
                if (!block_enable_i)
                    next_state = ST_STANDBY;
                else if (locked_now)
                    next_state = amplifier_on_request_i ? ST_TRANSMIT : ST_READY;
            end
            ST_READY:
            begin
                if (!block_enable_i)
                    next_state = ST_STANDBY;
                else if (amplifier_on_request_i)
                    next_state = ST_TRANSMIT;
            end
            ST_TRANSMIT:
            begin
                if (!block_enable_i)
                    next_state = ST_STANDBY;
                else if (!amplifier_on_request_i)
                    next_state = ST_READY;
            end
            default:
            begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
            state <= ST_STANDBY;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // lock and settle timer
    // ------------------------------------------------------------------
    // saturates so a long enable never wraps back into "not locked"
    always @(posedge clk_i)
    begin
        if (rst_i || !block_enable_i)
            enable_cnt <= {`RFTS_CNT_W{1'b0}};
        else if (!settled_now)
            enable_cnt <= enable_cnt + 20'h00001;
    end

    // ------------------------------------------------------------------
    // analog block enables
    // ------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            crystal_oscillator_on_o <= 1'b0;
            pll_on_o                <= 1'b0;
            clk_driver_on_o         <= 1'b0;
            amplifier_on_o          <= 1'b0;
            mode_o                  <= `RFTS_MODE_STANDBY;
        end
        else
        begin
            // block enable alone decides the reference side
            crystal_oscillator_on_o <= block_enable_i;
            pll_on_o                <= block_enable_i;
            clk_driver_on_o         <= block_enable_i;
            // amplifier is gated by block enable, so a stray request in
            // standby never powers it
            amplifier_on_o          <= block_enable_i & amplifier_on_request_i;
            mode_o                  <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // pll model
    // ------------------------------------------------------------------
    // carrier phase advances 32 steps per reference cycle once locked
    always @(posedge clk_i)
    begin
        if (rst_i || !block_enable_i)
        begin
            pll_locked_o    <= 1'b0;
            settled_o       <= 1'b0;
            pll_ratio_o     <= 6'h00;
            carrier_phase_o <= 16'h0000;
        end
        else
        begin
            pll_locked_o <= locked_now;
            settled_o    <= settled_now;
            pll_ratio_o  <= `RFTS_PLL_RATIO;
            if (locked_now)
                carrier_phase_o <= carrier_phase_o + {10'h000, `RFTS_PLL_RATIO};
        end
    end

    // ------------------------------------------------------------------
    // frequency keying
    // ------------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i || !block_enable_i)
            frequency_keying_high_o <= 1'b0;
        else
            frequency_keying_high_o <= ~keying_switch_closed_i;
    end

    // ------------------------------------------------------------------
    // clock output
    // ------------------------------------------------------------------
    assign clk_run = block_enable_i & clk_driver_on_o;

    rfts_clk_div4 u_clk_div
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .run_i       (clk_run),
        .clock_out_o (clock_out_o)
    );

    // ------------------------------------------------------------------
    // controller-side sequence checks
    // ------------------------------------------------------------------
    // flags are sticky until cleared; set and clear need opposite block enable
    // levels, so a new violation never meets a clear in the same cycle
    assign mod_edge = (amplifier_on_request_i != amp_req_prev) |
                      (amplifier_on_request_i & (keying_switch_closed_i != switch_prev));

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            amp_req_prev <= 1'b0;
            switch_prev  <= 1'b0;
        end
        else
        begin
            amp_req_prev <= amplifier_on_request_i;
            switch_prev  <= keying_switch_closed_i;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i || !block_enable_i)
        begin
            symbol_cnt  <= {`RFTS_CNT_W{1'b0}};
            symbol_seen <= 1'b0;
        end
        else if (mod_edge)
        begin
            symbol_cnt  <= {`RFTS_CNT_W{1'b0}};
            symbol_seen <= 1'b1;
        end
        else if (symbol_cnt < SYMBOL_CYCLES)
        begin
            symbol_cnt  <= symbol_cnt + 20'h00001;
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            early_amplifier_o     <= 1'b0;
            amplifier_while_off_o <= 1'b0;
            rate_violation_o      <= 1'b0;
        end
        else
        begin
            if (block_enable_i && amplifier_on_request_i && !settled_now)
                early_amplifier_o <= 1'b1;
            else if (!block_enable_i && !amplifier_on_request_i)
                early_amplifier_o <= 1'b0;

            if (!block_enable_i && amplifier_on_request_i)
                amplifier_while_off_o <= 1'b1;
            else if (block_enable_i && !amplifier_on_request_i)
                amplifier_while_off_o <= 1'b0;

            // only edges after the first one of an enable period count
            if (block_enable_i && mod_edge && symbol_seen && settled_now &&
                (symbol_cnt < SYMBOL_CYCLES - 1))
                rate_violation_o <= 1'b1;
            else if (!block_enable_i)
                rate_violation_o <= 1'b0;
        end
    end

endmodule

/* File: bench/rfts_seq_chk.sv */
// checker: pin relations of the enable sequencer
// assumes bind onto rfts_sequencer; one clock, sync reset
module rfts_seq_chk
#(
    parameter LOCK_CYCLES = 10
)
(
    // clock and reset
    input logic       clk_i,
    input logic       rst_i,
    // controller pins
    input logic       block_enable_i,
    input logic       amplifier_on_request_i,
    input logic       keying_switch_closed_i,
    // block outputs
    input logic       crystal_oscillator_on_o,
    input logic       pll_on_o,
    input logic       clk_driver_on_o,
    input logic       amplifier_on_o,
    input logic       clock_out_o,
    input logic [1:0] mode_o,
    input logic       pll_locked_o,
    input logic [5:0] pll_ratio_o,
    input logic       frequency_keying_high_o,
    input logic       amplifier_while_off_o,
    input logic [15:0] carrier_phase_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // edges seen with the driver on; any gap restarts the count
    logic [19:0] on_cnt;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !clk_driver_on_o)
            on_cnt <= 20'h0;
        else
            on_cnt <= on_cnt + 20'h1;
    end
    sequence s_steady;
        clk_driver_on_o [*4];
    endsequence
    sequence s_amp_no_en;
        !block_enable_i && amplifier_on_request_i;
    endsequence
    // ------
    // assertions
    // ------
    a_standby_off: assert property (
        !block_enable_i |=> !crystal_oscillator_on_o && !pll_on_o && !clk_driver_on_o
            && !amplifier_on_o && mode_o == 2'h0) else $error("standby left a block on");
    a_enable_on: assert property (
        block_enable_i |=> crystal_oscillator_on_o && pll_on_o && clk_driver_on_o)
        else $error("enable did not start blocks");
    a_amp_follow: assert property (
        block_enable_i |=> amplifier_on_o == $past(amplifier_on_request_i))
        else $error("amplifier not following request");
    a_amp_refused: assert property (
        s_amp_no_en |=> !amplifier_on_o && amplifier_while_off_o)
        else $error("request while off mishandled");
    a_lock_time: assert property (
        pll_locked_o == (clk_driver_on_o && on_cnt >= LOCK_CYCLES))
        else $error("lock at wrong cycle");
    a_pll_ratio: assert property (
        pll_ratio_o == (pll_on_o ? 6'h20 : 6'h00)) else $error("pll ratio wrong");
    a_key_freq: assert property (
        block_enable_i |=> frequency_keying_high_o == !$past(keying_switch_closed_i))
        else $error("wrong keyed frequency");
    a_clk_quarter: assert property (
        s_steady |-> clock_out_o != $past(clock_out_o, 2)) else $error("clock out not quarter");
    // once locked the carrier moves 32 steps per reference cycle
    a_carrier_step: assert property (
        pll_locked_o && block_enable_i |=> carrier_phase_o == $past(carrier_phase_o) + 16'h0020)
        else $error("carrier step wrong");
endmodule

/* File: bench/rfts_ctrl_model.sv */
// controller model: drives enable, amplifier request, keying switch
// assumes one cycle call per clock; pins move on falling edges
module rfts_ctrl_model
#(
    parameter LOCK   = 10,
    parameter SETTLE = 20
)
(
    // clock
    input  logic        clk_i,
    // pins to the transmitter
    output logic        block_enable_o,
    output logic        amplifier_on_request_o,
    output logic        keying_switch_closed_o,
    // outputs expected after the next rising edge
    output logic [14:0] expect_o,
    output logic        expect_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial
    begin
        block_enable_o = 1'b0;
        amplifier_on_request_o = 1'b0;
        keying_switch_closed_o = 1'b0;
        expect_o = 15'h0;
        expect_valid_o = 1'b0;
    end
    // a note covers one edge only
    always @(posedge clk_i)
        expect_valid_o <= 1'b0;
    task cycle(input logic en, input logic amp, input logic key);
        logic       lk;
        logic [1:0] md;
        @(negedge clk_i);
        cnt = en ? cnt + 1 : 0;
        lk = cnt >= LOCK + 1;
        md = !en ? 2'h0 : !lk ? 2'h1 : amp ? 2'h3 : 2'h2;
        block_enable_o = en;
        amplifier_on_request_o = amp;
        keying_switch_closed_o = key;
        expect_o = {{3{en}}, en & amp, en & !key, lk, cnt >= SETTLE + 1, md, en ? 6'h20 : 6'h00};
        expect_valid_o = 1'b1;
    endtask
    task hold();
        cycle(block_enable_o, amplifier_on_request_o, keying_switch_closed_o);
    endtask
    // amplifier kept low until settled, not only locked
    task power_up();
        repeat (SETTLE + 2) cycle(1'b1, 1'b0, 1'b0);
    endtask
    // fsk starts with an unkeyed carrier symbol so no two edges coincide
    task send(input logic frequency_keying, input logic [15:0] bits, input int gap);
        if (frequency_keying)
            repeat (gap) cycle(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 16; i++)
            repeat (gap) cycle(1'b1, frequency_keying | bits[i], frequency_keying & bits[i]);
    endtask
    task power_down();
        cycle(1'b1, 1'b0, 1'b0);
        cycle(1'b0, 1'b0, 1'b0);
    endtask
endmodule

/* File: bench/rf_transmitter_enable_sequencer_bench.sv */
// bench: controller model drives, queued notes are compared
// assumes design, checker and controller model compiled first
module rf_transmitter_enable_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK = 10;
    localparam int SETTLE = 20;
    localparam int SYM = 8;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wire         en, amp, key, osc, pll, drv, pa, clk_out, fkh, lk, st, early, off_req, rate;
    wire  [1:0]  mode;
    wire  [5:0]  ratio;
    wire  [14:0] exp_v;
    wire  [14:0] outs = {osc, pll, drv, pa, fkh, lk, st, mode, ratio};
    wire         exp_vld;
    logic [14:0] q[$];
    int          fails = 0;
    int          num_checks = 0;
    int          rises = 0;
    int          r0;
    rfts_sequencer #(.LOCK_CYCLES(LOCK), .SETTLE_CYCLES(SETTLE), .SYMBOL_CYCLES(SYM)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .block_enable_i(en), .amplifier_on_request_i(amp),
        .keying_switch_closed_i(key), .crystal_oscillator_on_o(osc), .pll_on_o(pll),
        .clk_driver_on_o(drv), .amplifier_on_o(pa), .clock_out_o(clk_out), .mode_o(mode),
        .pll_locked_o(lk), .settled_o(st), .pll_ratio_o(ratio), .frequency_keying_high_o(fkh),
        .carrier_phase_o(), .early_amplifier_o(early), .amplifier_while_off_o(off_req),
        .rate_violation_o(rate));
    rfts_ctrl_model #(.LOCK(LOCK), .SETTLE(SETTLE)) ctl_u (.clk_i(clk_i), .block_enable_o(en),
        .amplifier_on_request_o(amp), .keying_switch_closed_o(key), .expect_o(exp_v),
        .expect_valid_o(exp_vld));
    task check(input logic [14:0] seen, input logic [14:0] want);
        num_checks++;
        if (seen !== want)
        begin
            fails++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task wrap_up();
        $display("%0d checks, %0d mismatches", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_out)
        rises++;
    always @(posedge clk_i)
    begin
        if (exp_vld)
            q.push_back(exp_v);
    end
    always @(posedge clk_i)
    begin
        #1;
        while (q.size() > 0)
            check(outs, q.pop_front());
    end
    // a hang ends the run as a mismatch
    initial
    begin
        repeat (3000) @(posedge clk_i);
        fails++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'hf39f));
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (2) ctl_u.cycle(1'b0, 1'b1, 1'b0);
        ctl_u.hold();
        check(15'(off_req), 15'h1);
        ctl_u.power_up();
        check(15'(off_req), 15'h0);
        r0 = rises;
        repeat (40) ctl_u.hold();
        check(15'(rises - r0), 15'ha);
        $display("test 1 done");
        ctl_u.send(1'b0, 16'($urandom), SYM);
        ctl_u.send(1'b1, 16'($urandom), SYM);
        ctl_u.hold();
        check(15'(rate), 15'h0);
        ctl_u.power_down();
        $display("test 2 done");
        repeat (LOCK + 4) ctl_u.cycle(1'b1, 1'b0, 1'b0);
        repeat (SETTLE) ctl_u.cycle(1'b1, 1'b1, 1'b0);
        check(15'(early), 15'h1);
        ctl_u.send(1'b0, 16'h5555, 2);
        ctl_u.hold();
        check(15'(rate), 15'h1);
        ctl_u.power_down();
        ctl_u.hold();
        check({13'h0, early, rate}, 15'h0);
        $display("test 3 done");
        @(posedge clk_i);
        #2;
        wrap_up();
    end
endmodule

bind rfts_sequencer rfts_seq_chk #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .block_enable_i(block_enable_i),
    .amplifier_on_request_i(amplifier_on_request_i), .keying_switch_closed_i(keying_switch_closed_i),
    .crystal_oscillator_on_o(crystal_oscillator_on_o), .pll_on_o(pll_on_o),
    .clk_driver_on_o(clk_driver_on_o), .amplifier_on_o(amplifier_on_o), .clock_out_o(clock_out_o),
    .mode_o(mode_o), .pll_locked_o(pll_locked_o), .pll_ratio_o(pll_ratio_o),
    .frequency_keying_high_o(frequency_keying_high_o),
    .amplifier_while_off_o(amplifier_while_off_o), .carrier_phase_o(carrier_phase_o));
